/* File: design/psom_top.sv */
// Pin six output source multiplexer with its APB control registers and pin driver.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
module psom_top
  import psom_pkg::*;
#(
  parameter int unsigned NRX = 4,
  parameter int unsigned NTX = 2,
  parameter int unsigned NGP = 4
) (
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NRX*NGP-1:0] rx_remote_gpio,
  input  wire logic [NRX-1:0]     rx_lock,
  input  wire logic [NRX-1:0]     rx_pass,
  input  wire logic [NRX-1:0]     rx_fv,
  input  wire logic [NRX-1:0]     rx_lv,
  input  wire logic               sync_generator_pulse,
  input  wire logic [NTX-1:0]     tx_fv,
  input  wire logic [NTX-1:0]     tx_lv,
  input  wire logic [NTX-1:0]     tx_synced,
  output logic                    pin_out,
  output logic                    pin_oe
);

  // Reset release through two flip-flops; only the second copy feeds the design.
  logic rst_meta_ff;
  logic rst_n_ff;
  logic nxt_rst_meta;
  logic nxt_rst_n;

  always_comb begin
    nxt_rst_meta = 1'b1;
    nxt_rst_n    = rst_meta_ff;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= nxt_rst_meta;
      rst_n_ff    <= nxt_rst_n;
    end
  end

  // Remote inputs cross from the link recovery logic, so they are resynchronised.
  logic [NRX*NGP-1:0] remote_gpio_s;

  psom_sync #(
    .WIDTH    (NRX*NGP)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n_ff),
    .async_in (rx_remote_gpio),
    .sync_out (remote_gpio_s)
  );

  // Registers.
  logic [7:0] pin_six_output_control_ff;
  logic [7:0] port_config_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] nxt_pcfg;

  logic [2:0] pin_signal_selector;
  logic [2:0] pin_source_selector;
  logic       pin_software_level;
  logic       pin_driver_enable;

  always_comb begin
    pin_signal_selector = pin_six_output_control_ff[SEL_LSB +: CODE_W];
    pin_source_selector = pin_six_output_control_ff[SRC_LSB +: CODE_W];
    pin_software_level  = pin_six_output_control_ff[VAL_BIT];
    pin_driver_enable   = pin_six_output_control_ff[EN_BIT];
  end

  logic dev_lock_or;
  logic dev_pass_and;
  logic [NTX-1:0] tx_pass_and;
  logic [NTX-1:0] tx_pass_or;

  psom_reduce #(
    .NRX          (NRX),
    .NTX          (NTX)
  ) u_reduce (
    .mclk         (mclk),
    .rst_n        (rst_n_ff),
    .rx_lock      (rx_lock),
    .rx_pass      (rx_pass),
    .rx_en        (port_config_ff[RXEN_LSB +: NRX]),
    .tx_map       (port_config_ff[TXMAP_LSB +: NRX]),
    .dev_lock_or  (dev_lock_or),
    .dev_pass_and (dev_pass_and),
    .tx_pass_and  (tx_pass_and),
    .tx_pass_or   (tx_pass_or)
  );

  // APB slave: one wait-free access phase, answers registered.
  psom_state_e state_ff;
  psom_state_e nxt_state;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic        hit_ctl;
  logic        hit_stat;
  logic        hit_pcfg;
  logic        code_reserved;

  always_comb begin
    hit_ctl  = 1'b0;
    hit_stat = 1'b0;
    hit_pcfg = 1'b0;
    if (paddr == CTL_ADDR) begin
      hit_ctl = 1'b1;
    end else if (paddr == STAT_ADDR) begin
      hit_stat = 1'b1;
    end else if (paddr == PCFG_ADDR) begin
      hit_pcfg = 1'b1;
    end
  end

  always_comb begin
    nxt_state   = state_ff;
    nxt_prdata  = prdata;
    nxt_pready  = 1'b0;
    nxt_pslverr = pslverr;
    nxt_ctl     = pin_six_output_control_ff;
    nxt_pcfg    = port_config_ff;
    case (state_ff)
      ST_IDLE: begin
        if (psel && !penable) begin
          nxt_state   = ST_ACC;
          nxt_pready  = 1'b1;
          nxt_pslverr = !(hit_ctl || hit_stat || hit_pcfg);
          nxt_prdata  = 32'h0000_0000;
          if (!pwrite) begin
            if (hit_ctl) begin
              nxt_prdata = {24'h00_0000, pin_six_output_control_ff};
            end else if (hit_stat) begin
              nxt_prdata = {29'h0000_0000, code_reserved, pin_oe, pin_out};
            end else if (hit_pcfg) begin
              nxt_prdata = {24'h00_0000, port_config_ff};
            end
          end
        end
      end
      ST_ACC: begin
        nxt_state   = ST_IDLE;
        nxt_pslverr = 1'b0;
        // Writes land only on the completing edge; lane 0 carries all eight bits.
        if (psel && penable && pwrite && pstrb[0]) begin
          if (hit_ctl) begin
            nxt_ctl = pwdata[7:0];
          end else if (hit_pcfg) begin
            nxt_pcfg = pwdata[7:0];
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff                  <= ST_IDLE;
      prdata                    <= 32'h0000_0000;
      pready                    <= 1'b0;
      pslverr                   <= 1'b0;
      pin_six_output_control_ff <= CTL_RST;
      port_config_ff            <= PCFG_RST;
    end else begin
      state_ff                  <= nxt_state;
      prdata                    <= nxt_prdata;
      pready                    <= nxt_pready;
      pslverr                   <= nxt_pslverr;
      pin_six_output_control_ff <= nxt_ctl;
      port_config_ff            <= nxt_pcfg;
    end
  end

  // Source and selector decode.
  logic       nxt_pin_out;
  logic       nxt_pin_oe;
  logic [1:0] rx_idx;
  logic       tx_idx;
  logic [NGP-1:0] rx_gp;

  always_comb begin
    rx_idx        = pin_source_selector[1:0];
    tx_idx        = pin_source_selector[0];
    rx_gp         = remote_gpio_s[rx_idx*NGP +: NGP];
    nxt_pin_out   = 1'b0;
    code_reserved = 1'b0;
    if (pin_source_selector <= SRC_RX3) begin
      case (pin_signal_selector)
        SEL_0: nxt_pin_out = rx_gp[0];
        SEL_1: nxt_pin_out = rx_gp[1];
        SEL_2: nxt_pin_out = rx_gp[3];
        // The undefined code is taken as remote input 2, the one left over.
        SEL_3: nxt_pin_out = rx_gp[2];
        SEL_4: nxt_pin_out = rx_lock[rx_idx];
        SEL_5: nxt_pin_out = rx_pass[rx_idx];
        SEL_6: nxt_pin_out = rx_fv[rx_idx];
        default: nxt_pin_out = rx_lv[rx_idx];
      endcase
    end else if (pin_source_selector == SRC_DEV) begin
      case (pin_signal_selector)
        SEL_0: nxt_pin_out = pin_software_level;
        SEL_1: nxt_pin_out = dev_lock_or;
        SEL_2: nxt_pin_out = dev_pass_and;
        SEL_3: nxt_pin_out = dev_pass_and;
        SEL_4: nxt_pin_out = sync_generator_pulse;
        default: code_reserved = 1'b1;
      endcase
    end else if (pin_source_selector == SRC_RSV) begin
      code_reserved = 1'b1;
    end else begin
      case (pin_signal_selector)
        SEL_0: nxt_pin_out = tx_pass_and[tx_idx];
        SEL_1: nxt_pin_out = tx_pass_or[tx_idx];
        SEL_2: nxt_pin_out = tx_fv[tx_idx];
        SEL_3: nxt_pin_out = tx_lv[tx_idx];
        SEL_4: nxt_pin_out = tx_synced[tx_idx];
        default: code_reserved = 1'b1;
      endcase
    end
    // A released pin also drives its data low, so no stale level leaks out.
    nxt_pin_oe = pin_driver_enable;
    if (!pin_driver_enable) begin
      nxt_pin_out = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= nxt_pin_out;
      pin_oe  <= nxt_pin_oe;
    end
  end

endmodule

/* File: design/psom_pkg.sv */
// Shared constants for the pin six output source multiplexer.
package psom_pkg;

  // Register indexes; the byte address on APB is four times the index.
  localparam logic [7:0]  CTL_IDX   = 8'h16;
  localparam logic [7:0]  STAT_IDX  = 8'h20;
  localparam logic [7:0]  PCFG_IDX  = 8'h21;
  localparam int unsigned ADDR_W    = 12;
  localparam logic [11:0] CTL_ADDR  = {2'b00, CTL_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {2'b00, STAT_IDX, 2'b00};
  localparam logic [11:0] PCFG_ADDR = {2'b00, PCFG_IDX, 2'b00};

  // Reset values.
  localparam logic [7:0]  CTL_RST   = 8'h00;
  localparam logic [7:0]  PCFG_RST  = 8'h0F;

  // Field positions of the control register.
  localparam int unsigned EN_BIT    = 0;
  localparam int unsigned VAL_BIT   = 1;
  localparam int unsigned SRC_LSB   = 2;
  localparam int unsigned SEL_LSB   = 5;
  localparam int unsigned CODE_W    = 3;

  // Field positions of the port configuration register.
  localparam int unsigned RXEN_LSB  = 0;
  localparam int unsigned TXMAP_LSB = 4;

  // Source codes.
  localparam logic [2:0]  SRC_RX3   = 3'h3;
  localparam logic [2:0]  SRC_DEV   = 3'h4;
  localparam logic [2:0]  SRC_RSV   = 3'h5;
  localparam logic [2:0]  SRC_TX0   = 3'h6;
  localparam logic [2:0]  SRC_TX1   = 3'h7;

  // Selector codes.
  localparam logic [2:0]  SEL_0     = 3'h0;
  localparam logic [2:0]  SEL_1     = 3'h1;
  localparam logic [2:0]  SEL_2     = 3'h2;
  localparam logic [2:0]  SEL_3     = 3'h3;
  localparam logic [2:0]  SEL_4     = 3'h4;
  localparam logic [2:0]  SEL_5     = 3'h5;
  localparam logic [2:0]  SEL_6     = 3'h6;
  localparam logic [2:0]  SEL_7     = 3'h7;

  // Bus slave states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC  = 2'b10
  } psom_state_e;

endpackage

/* File: design/psom_sync.sv */
// Two flip-flop synchroniser bank for inputs arriving from outside the clock domain.
`timescale 1ns/100ps
module psom_sync #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= nxt_meta;
      sync_out <= nxt_sync;
    end
  end

endmodule

/* File: design/psom_reduce.sv */
// Registered reductions over enabled receive ports: lock and pass device wide, pass only per transmitter.
`timescale 1ns/100ps
module psom_reduce #(
  parameter int unsigned NRX = 4,
  parameter int unsigned NTX = 2
) (
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic [NRX-1:0] rx_lock,
  input  wire logic [NRX-1:0] rx_pass,
  input  wire logic [NRX-1:0] rx_en,
  input  wire logic [NRX-1:0] tx_map,
  output logic                dev_lock_or,
  output logic                dev_pass_and,
  output logic      [NTX-1:0] tx_pass_and,
  output logic      [NTX-1:0] tx_pass_or
);

  logic           nxt_dev_lock_or;
  logic           nxt_dev_pass_and;
  logic [NTX-1:0] nxt_tx_pass_and;
  logic [NTX-1:0] nxt_tx_pass_or;

  // An AND over an empty set reads low so that a disabled hub never claims a pass.
  always_comb begin
    nxt_dev_lock_or  = |(rx_lock & rx_en);
    nxt_dev_pass_and = (|rx_en) && ((rx_pass | ~rx_en) == '1);
  end

  for (genvar t = 0; t < NTX; t++) begin : g_tx
    logic [NRX-1:0] member;
    always_comb begin
      for (int i = 0; i < NRX; i++) begin
        member[i] = rx_en[i] && (tx_map[i] == (t[0] == 1'b1));
      end
      nxt_tx_pass_and[t] = (|member) && ((rx_pass | ~member) == '1);
      nxt_tx_pass_or[t]  = |(rx_pass & member);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dev_lock_or  <= 1'b0;
      dev_pass_and <= 1'b0;
      tx_pass_and  <= '0;
      tx_pass_or   <= '0;
    end else begin
      dev_lock_or  <= nxt_dev_lock_or;
      dev_pass_and <= nxt_dev_pass_and;
      tx_pass_and  <= nxt_tx_pass_and;
      tx_pass_or   <= nxt_tx_pass_or;
    end
  end

endmodule

/* File: sim/psom_props.sv */
// Concurrent checks on the ports of the pin six output multiplexer.
`timescale 1ns/100ps
module psom_props
  import psom_pkg::*;
#(
  parameter int unsigned NRX = 4,
  parameter int unsigned NTX = 2,
  parameter int unsigned NGP = 4
) (
  input wire logic               mclk,
  input wire logic               nrst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [NRX*NGP-1:0] rx_remote_gpio,
  input wire logic [NRX-1:0]     rx_lock,
  input wire logic [NRX-1:0]     rx_pass,
  input wire logic [NRX-1:0]     rx_fv,
  input wire logic [NRX-1:0]     rx_lv,
  input wire logic               sync_generator_pulse,
  input wire logic [NTX-1:0]     tx_fv,
  input wire logic [NTX-1:0]     tx_lv,
  input wire logic [NTX-1:0]     tx_synced,
  input wire logic               pin_out,
  input wire logic               pin_oe
);
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [2:0] src;
  logic [2:0] sel;
  logic       wr_ctl;
  logic       mapped;
  logic       rsv;
  logic       lock_pick;
  logic       txfv_pick;

  // Shadow of the control register, so pin checks know which source is live.
  always_comb begin
    wr_ctl    = psel && penable && pready && pwrite && pstrb[0] && (paddr == CTL_ADDR);
    mapped    = paddr inside {CTL_ADDR, STAT_ADDR, PCFG_ADDR};
    nxt_sh    = wr_ctl ? pwdata[7:0] : sh_ff;
    src       = sh_ff[4:2];
    sel       = sh_ff[7:5];
    rsv       = sh_ff[0] && ((src == SRC_RSV) || (src[2] && sel >= SEL_5));
    lock_pick = rx_lock[sh_ff[3:2]];
    txfv_pick = tx_fv[sh_ff[2]];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sh_ff <= CTL_RST;
    end else begin
      sh_ff <= nxt_sh;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence done_s;
    psel && penable && pready;
  endsequence

  setup_ready_a: assert property (setup_s |=> done_s)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (done_s |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property ((psel && penable && pready && !mapped) |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  ctl_read_a: assert property ((psel && penable && pready && !pwrite && paddr == CTL_ADDR) |->
    prdata == {24'h0, sh_ff}) else $error("control read back wrong");
  enable_follow_a: assert property (wr_ctl |-> ##2 (pin_oe == $past(pwdata[EN_BIT], 2)))
    else $error("driver enable not following control");
  idle_low_a: assert property (!pin_oe |-> !pin_out)
    else $error("pin data while released");
  soft_level_a: assert property ((sh_ff[0] && src == SRC_DEV && sel == SEL_0) |=>
    pin_out == $past(sh_ff[VAL_BIT])) else $error("software level not on pin");
  rsv_low_a: assert property (rsv |=> !pin_out)
    else $error("reserved code drives pin high");
  rx_lock_a: assert property ((sh_ff[0] && !src[2] && sel == SEL_4) |=>
    pin_out == $past(lock_pick)) else $error("receive lock not on pin");
  tx_frame_a: assert property ((sh_ff[0] && src[2:1] == 2'b11 && sel == SEL_2) |=>
    pin_out == $past(txfv_pick)) else $error("transmit frame not on pin");
  // Checked one edge on, so the unknown state before the first edge is never judged.
  reset_clear_a: assert property (disable iff (1'b0) !nrst |=> !pin_oe && !pin_out && !pready)
    else $error("outputs not cleared in reset");
endmodule

bind psom_top psom_props #(.NRX(NRX), .NTX(NTX), .NGP(NGP)) u_props (
  .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_remote_gpio(rx_remote_gpio), .rx_lock(rx_lock),
  .rx_pass(rx_pass), .rx_fv(rx_fv), .rx_lv(rx_lv),
  .sync_generator_pulse(sync_generator_pulse), .tx_fv(tx_fv), .tx_lv(tx_lv),
  .tx_synced(tx_synced), .pin_out(pin_out), .pin_oe(pin_oe)
);

/* File: sim/psom_pin_watch.sv */
// Board logic that samples pin six.
`timescale 1ns/100ps
module psom_pin_watch (
  input  wire logic mclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  logic float_ff = 1'b0;

  // The pin has no pull, so a released pin toggles each cycle instead of keeping old data.
  always_ff @(posedge mclk) begin
    float_ff <= pin_oe ? ~pin_out : ~float_ff;
  end

  assign pin_level = pin_oe ? pin_out : float_ff;
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the pin six output multiplexer.
`timescale 1ns/100ps
module tb_top;
  import psom_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] gp = 16'h0;
  logic [3:0]  lock = 4'h0, pass = 4'h0, fv = 4'h0, lv = 4'h0;
  logic        fs = 1'b0;
  logic [1:0]  txfv = 2'h0, txlv = 2'h0, txs = 2'h0;
  logic        pin_out, pin_oe, pin_level, e;
  logic [7:0]  pcfg = 8'h0F;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          samples_checked = 0;

  always #10 mclk = ~mclk;

  psom_top dut (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_remote_gpio(gp), .rx_lock(lock), .rx_pass(pass),
    .rx_fv(fv), .rx_lv(lv), .sync_generator_pulse(fs), .tx_fv(txfv), .tx_lv(txlv),
    .tx_synced(txs), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  psom_pin_watch u_watch (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  task automatic close_out();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Reads happen in the active region after the edge, so they see pre-edge values.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    check(n, 1, "ready wait");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic ref_pin(input logic [2:0] src, input logic [2:0] sel, input logic v);
    int         p;
    logic [3:0] m;
    logic       pand;
    logic [7:0] rxv, devv, txv;
    p = src[1:0];
    m = pcfg[3:0] & (src[0] ? pcfg[7:4] : ~pcfg[7:4]);
    pand = (pcfg[3:0] != 4'h0) && ((pass & pcfg[3:0]) == pcfg[3:0]);
    rxv = {lv[p], fv[p], pass[p], lock[p], gp[4*p+2], gp[4*p+3], gp[4*p+1], gp[4*p]};
    devv = {3'h0, fs, pand, pand, |(lock & pcfg[3:0]), v};
    txv = {3'h0, txs[p%2], txlv[p%2], txfv[p%2], |(pass & m), (m != 4'h0) && ((pass & m) == m)};
    if (src == SRC_RSV) return 1'b0;
    if (src == SRC_DEV) return devv[sel];
    return src[2] ? txv[sel] : rxv[sel];
  endfunction

  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    pcfg = PCFG_RST;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    apb(1'b0, CTL_ADDR, 32'h0, 4'hF); check(rd, 32'h0, "ctl reset");
    apb(1'b0, PCFG_ADDR, 32'h0, 4'hF); check(rd, {24'h0, PCFG_RST}, "cfg reset");
    apb(1'b1, 12'hFFC, 32'hFF, 4'hF); check(err, 1'b1, "unmapped err");
    apb(1'b1, CTL_ADDR, 32'hFF, 4'h0);
    apb(1'b1, STAT_ADDR, 32'hFF, 4'hF);
    apb(1'b0, CTL_ADDR, 32'h0, 4'hF); check(rd, 32'h0, "ignored writes");
    for (int k = 0; k < 2; k++) begin
      gp <= k ? 16'hA5C3 : 16'h3C96;
      lock <= k ? 4'hA : 4'h4;
      pass <= k ? 4'h5 : 4'hB;
      fv <= k ? 4'h9 : 4'h6;
      lv <= k ? 4'h6 : 4'h9;
      fs <= k ? 1'b0 : 1'b1;
      txfv <= k ? 2'h2 : 2'h1;
      txlv <= k ? 2'h1 : 2'h2;
      txs <= k ? 2'h1 : 2'h3;
      if (k == 1) begin
        apb(1'b1, PCFG_ADDR, 32'hA5, 4'h1);
        pcfg = 8'hA5;
      end
      for (int c = 0; c < 128; c++) begin
        apb(1'b1, CTL_ADDR, {24'h0, c[6:0], 1'b1}, 4'h1);
        repeat (5) @(posedge mclk);
        e = ref_pin(c[3:1], c[6:4], c[0]);
        check({pin_oe, pin_level}, {1'b1, e}, "pin");
      end
    end
    apb(1'b1, CTL_ADDR, 32'h13, 4'h1);
    apb(1'b0, STAT_ADDR, 32'h0, 4'hF); check(rd, 32'h3, "status driven");
    apb(1'b1, CTL_ADDR, 32'h12, 4'h1);
    repeat (3) @(posedge mclk);
    check({pin_oe, pin_out}, 2'b00, "released pin");
    apb(1'b1, CTL_ADDR, 32'h15, 4'h1);
    apb(1'b0, STAT_ADDR, 32'h0, 4'hF); check(rd, 32'h6, "status reserved");
    do_reset();
    check({pin_oe, pin_out}, 2'b00, "pin after reset");
    apb(1'b0, CTL_ADDR, 32'h0, 4'hF); check(rd, 32'h0, "ctl after reset");
    apb(1'b0, PCFG_ADDR, 32'h0, 4'hF); check(rd, {24'h0, PCFG_RST}, "cfg after reset");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule
